// [src/tmr2_core.v]
/*
  timer 2: 16-bit counter with auto reload, capture and baud generator
  modes, a byte register port and a level interrupt.
  assumes the external pins are asynchronous and the register port is
  driven on clk_sys_in with one-cycle strobes.
*/
`timescale 1ns/1ps
`include "tmr2_regs.vh"

module tmr2_core #(
  parameter CNT_W = 16
) (
  input  wire       clk_sys_in,
  input  wire       rst_in,
  input  wire       clk_en_in,
  input  wire [7:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  output reg  [7:0] rdata_out,
  input  wire       ext_count_pin_in,
  input  wire       trigger_pin_in,
  output reg        tx_baud_tick_out,
  output reg        rx_baud_tick_out,
  output wire       irq_out
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg [7:0]       timer2_control_r;
  reg [CNT_W-1:0] count_r;
  reg [CNT_W-1:0] capture_r;
  reg [7:0]       sys_r;
  reg [`TMR2_IRQ_W-1:0] irq_stat_r;
  reg [`TMR2_IRQ_W-1:0] irq_en_r;
  reg [2:0]       cnt_pin_sync_r;
  reg [2:0]       trg_pin_sync_r;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire wr_ctrl  = wr_in && (addr_in == `TMR2_ADDR_CTRL);
  wire wr_cnlo  = wr_in && (addr_in == `TMR2_ADDR_CNT_LO);
  wire wr_cnhi  = wr_in && (addr_in == `TMR2_ADDR_CNT_HI);
  wire wr_cplo  = wr_in && (addr_in == `TMR2_ADDR_CAP_LO);
  wire wr_cphi  = wr_in && (addr_in == `TMR2_ADDR_CAP_HI);
  wire wr_sys   = wr_in && (addr_in == `TMR2_ADDR_SYS);
  wire wr_ien   = wr_in && (addr_in == `TMR2_ADDR_IRQ_EN);
  wire wr_iclr  = wr_in && (addr_in == `TMR2_ADDR_IRQ_CLR);

  wire capture_reload_select = timer2_control_r[`TMR2_B_CRSEL];
  wire count_source_select   = timer2_control_r[`TMR2_B_CSRC];
  wire run_control           = timer2_control_r[`TMR2_B_RUN];
  wire trigger_enable        = timer2_control_r[`TMR2_B_TRGEN];
  wire tx_clock_select       = timer2_control_r[`TMR2_B_TXSEL];
  wire rx_clock_select       = timer2_control_r[`TMR2_B_RXSEL];
  wire power_down            = sys_r[`TMR2_B_PDOWN];
  wire [1:0] serial_mode     = sys_r[`TMR2_B_SMODE+1:`TMR2_B_SMODE];

  // mode selection from the three select bits only
  wire mode_baud    = tx_clock_select | rx_clock_select;
  wire mode_capture = ~mode_baud & capture_reload_select;
  wire mode_reload  = ~mode_baud & ~capture_reload_select;

  // ------------------------------------------------------------
  // pin synchronisers and falling edge detection
  // ------------------------------------------------------------
  // stage 0 only feeds stage 1; edges are taken between stages 1 and 2
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt_pin_sync_r <= `TMR2_SYNC_IDLE;
      trg_pin_sync_r <= `TMR2_SYNC_IDLE;
    end else if (clk_en_in) begin
      cnt_pin_sync_r <= {cnt_pin_sync_r[1:0], ext_count_pin_in};
      trg_pin_sync_r <= {trg_pin_sync_r[1:0], trigger_pin_in};
    end
  end

  wire cnt_fall = cnt_pin_sync_r[2] & ~cnt_pin_sync_r[1];
  wire trg_fall = trg_pin_sync_r[2] & ~trg_pin_sync_r[1] & trigger_enable;

  // ------------------------------------------------------------
  // counting
  // ------------------------------------------------------------
  wire count_tick = count_source_select ? cnt_fall : 1'b1;
  wire counting   = run_control & ~power_down & count_tick;
  wire carry      = counting && (count_r == `TMR2_CNT_MAX);
  wire do_capture = mode_capture & trg_fall;
  wire trg_reload = mode_reload & trg_fall;
  wire do_reload  = (carry & ~mode_capture) | trg_reload;
  wire set_ovf    = carry & ~mode_baud;
  wire set_trg    = trg_fall;
  wire serial_ok  = (serial_mode == `TMR2_SMODE_1) ||
                    (serial_mode == `TMR2_SMODE_3);

  // merge a byte write into one half of a word
  function [CNT_W-1:0] put_byte;
    input [CNT_W-1:0] word;
    input [7:0]       data;
    input             hi;
    begin
      put_byte = hi ? {data, word[7:0]} : {word[CNT_W-1:8], data};
    end
  endfunction

  // counter register: software write, reload, increment
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      count_r <= `TMR2_RST_WORD;
    end else if (clk_en_in) begin
      if (wr_cnlo || wr_cnhi) begin
        count_r <= put_byte(count_r, wdata_in, wr_cnhi);
      end else if (do_reload) begin
        count_r <= capture_r;
      end else if (counting) begin
        count_r <= count_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // capture/reload pair: capture has priority over a software write
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      capture_r <= `TMR2_RST_WORD;
    end else if (clk_en_in) begin
      if (do_capture) begin
        capture_r <= count_r;
      end else if (wr_cplo || wr_cphi) begin
        capture_r <= put_byte(capture_r, wdata_in, wr_cphi);
      end
    end
  end

  // ------------------------------------------------------------
  // control register with hardware flags
  // ------------------------------------------------------------
  reg [7:0] ctrl_nxt;
  always @* begin
    ctrl_nxt = timer2_control_r;
    if (wr_ctrl) begin
      ctrl_nxt = wdata_in;
    end
    if (set_ovf) begin
      ctrl_nxt[`TMR2_B_OVF] = 1'b1;
    end
    if (set_trg) begin
      ctrl_nxt[`TMR2_B_TRGF] = 1'b1;
    end
  end

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      timer2_control_r <= `TMR2_RST_BYTE;
      sys_r            <= `TMR2_RST_BYTE;
    end else if (clk_en_in) begin
      timer2_control_r <= ctrl_nxt;
      if (wr_sys) begin
        sys_r <= wdata_in;
      end
    end
  end

  // ------------------------------------------------------------
  // serial port clock ticks
  // ------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      tx_baud_tick_out <= 1'b0;
      rx_baud_tick_out <= 1'b0;
    end else if (clk_en_in) begin
      tx_baud_tick_out <= carry & tx_clock_select & serial_ok;
      rx_baud_tick_out <= carry & rx_clock_select & serial_ok;
    end
  end

  // ------------------------------------------------------------
  // interrupt status, enable, clear
  // ------------------------------------------------------------
  wire [`TMR2_IRQ_W-1:0] irq_evt = {do_capture, set_trg, set_ovf};
  wire [`TMR2_IRQ_W-1:0] irq_clr = wr_iclr ? wdata_in[`TMR2_IRQ_W-1:0]
                                           : {`TMR2_IRQ_W{1'b0}};

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      irq_stat_r <= {`TMR2_IRQ_W{1'b0}};
      irq_en_r   <= {`TMR2_IRQ_W{1'b0}};
    end else if (clk_en_in) begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
      if (wr_ien) begin
        irq_en_r <= wdata_in[`TMR2_IRQ_W-1:0];
      end
    end
  end

  assign irq_out = |(irq_stat_r & irq_en_r);

  // ------------------------------------------------------------
  // read port: data one cycle after the strobe
  // ------------------------------------------------------------
  reg [7:0] rd_mux;
  always @* begin
    case (addr_in)
      `TMR2_ADDR_CTRL:     rd_mux = timer2_control_r;
      `TMR2_ADDR_CNT_LO:   rd_mux = count_r[7:0];
      `TMR2_ADDR_CNT_HI:   rd_mux = count_r[CNT_W-1:8];
      `TMR2_ADDR_CAP_LO:   rd_mux = capture_r[7:0];
      `TMR2_ADDR_CAP_HI:   rd_mux = capture_r[CNT_W-1:8];
      `TMR2_ADDR_SYS:      rd_mux = sys_r;
      `TMR2_ADDR_IRQ_STAT: rd_mux = {{(8-`TMR2_IRQ_W){1'b0}}, irq_stat_r};
      `TMR2_ADDR_IRQ_EN:   rd_mux = {{(8-`TMR2_IRQ_W){1'b0}}, irq_en_r};
      default:             rd_mux = `TMR2_RST_BYTE;
    endcase
  end

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      rdata_out <= `TMR2_RST_BYTE;
    end else if (clk_en_in) begin
      rdata_out <= rd_in ? rd_mux : `TMR2_RST_BYTE;
    end
  end

endmodule

// [include/tmr2_regs.vh]
/*
  register map, field positions and reset values of timer 2.
  assumes a byte-wide register port with byte-indexed offsets.
*/
`ifndef TMR2_REGS_VH
`define TMR2_REGS_VH

// ------------------------------------------------------------
// register offsets (8-bit address)
// ------------------------------------------------------------
`define TMR2_ADDR_CTRL      8'hC8
`define TMR2_ADDR_CNT_LO    8'hC9
`define TMR2_ADDR_CNT_HI    8'hCA
`define TMR2_ADDR_CAP_LO    8'hCB
`define TMR2_ADDR_CAP_HI    8'hCC
`define TMR2_ADDR_SYS       8'hCD
`define TMR2_ADDR_IRQ_STAT  8'hCE
`define TMR2_ADDR_IRQ_EN    8'hCF
`define TMR2_ADDR_IRQ_CLR   8'hD0

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define TMR2_B_CRSEL   0
`define TMR2_B_CSRC    1
`define TMR2_B_RUN     2
`define TMR2_B_TRGEN   3
`define TMR2_B_TXSEL   4
`define TMR2_B_RXSEL   5
`define TMR2_B_TRGF    6
`define TMR2_B_OVF     7

// system register fields: power-down, serial mode (2 bits)
`define TMR2_B_PDOWN   0
`define TMR2_B_SMODE   1

// interrupt bits
`define TMR2_I_OVF     0
`define TMR2_I_TRG     1
`define TMR2_I_CAP     2

`define TMR2_RST_BYTE  8'h00
`define TMR2_RST_WORD  16'h0000
`define TMR2_IRQ_W     3
`define TMR2_SMODE_1   2'h1
`define TMR2_SMODE_3   2'h3
`define TMR2_CNT_MAX   16'hFFFF
// pin synchroniser chains rest at the idle-high pin level
`define TMR2_SYNC_IDLE 3'h7

`endif

// [tb/tmr2_props.sv]
/* timer 2 port checker, bound into tmr2_core.
   assumes one clock and clk_en_in held high. */
`timescale 1ns/1ps
module tmr2_props (
  input wire       clk_sys_in,
  input wire       rst_in,
  input wire       clk_en_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire       wr_in,
  input wire       rd_in,
  input wire [7:0] rdata_out,
  input wire       ext_count_pin_in,
  input wire       trigger_pin_in,
  input wire       tx_baud_tick_out,
  input wire       rx_baud_tick_out,
  input wire       irq_out
);
  reg [5:0] ctl_r;
  reg [2:0] sys_r;
  reg [2:0] ien_r;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // shadow of the fields only software writes
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctl_r <= 6'h00;
      sys_r <= 3'h0;
      ien_r <= 3'h0;
    end else if (wr_in && clk_en_in) begin
      if (addr_in == 8'hC8) ctl_r <= wdata_in[5:0];
      if (addr_in == 8'hCD) sys_r <= wdata_in[2:0];
      if (addr_in == 8'hCF) ien_r <= wdata_in[2:0];
    end
  end
  chk_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  chk_unmapped_zero: assert property (rd_in && (addr_in < 8'hC8 || addr_in > 8'hD0)
    |=> rdata_out == 8'h00) else $error("unmapped read not zero");
  chk_ctrl_readback: assert property (rd_in && addr_in == 8'hC8
    |=> rdata_out[5:0] == $past(ctl_r)) else $error("control bits read back wrong");
  chk_ien_readback: assert property (rd_in && addr_in == 8'hCF
    |=> rdata_out[2:0] == $past(ien_r)) else $error("irq enable read back wrong");
  chk_irq_gated: assert property (ien_r == 3'h0 |-> !irq_out)
    else $error("interrupt with all enables off");
  chk_tx_needs_sel: assert property (tx_baud_tick_out |-> ($past(ctl_r[4])
    || $past(ctl_r[4], 2)) && ($past(sys_r[1]) || $past(sys_r[1], 2)))
    else $error("transmit tick without select or serial mode");
  chk_rx_needs_sel: assert property (rx_baud_tick_out |-> ($past(ctl_r[5])
    || $past(ctl_r[5], 2)) && ($past(sys_r[1]) || $past(sys_r[1], 2)))
    else $error("receive tick without select or serial mode");
  chk_halt_no_tick: assert property ((tx_baud_tick_out || rx_baud_tick_out)
    |-> ($past(ctl_r[2]) || $past(ctl_r[2], 2)) && !($past(sys_r[0]) && $past(sys_r[0], 2)))
    else $error("tick while halted");
endmodule
bind tmr2_core tmr2_props u_props (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
  .clk_en_in(clk_en_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .ext_count_pin_in(ext_count_pin_in),
  .trigger_pin_in(trigger_pin_in), .tx_baud_tick_out(tx_baud_tick_out),
  .rx_baud_tick_out(rx_baud_tick_out), .irq_out(irq_out));

// [tb/tmr2_pin_model.sv]
/* pin side of timer 2: trigger and count pins, serial port tick counters.
   assumes the bench calls its tasks after a rising edge. */
`timescale 1ns/1ps
module tmr2_pin_model (
  input  wire clk_sys_in,
  input  wire tx_tick_in,
  input  wire rx_tick_in,
  output reg  trigger_pin_out,
  output reg  ext_count_pin_out
);
  integer tx_cnt = 0;
  integer rx_cnt = 0;
  initial trigger_pin_out = 1'b1;
  initial ext_count_pin_out = 1'b1;
  // serial port in mode 1 or 3 takes every tick it gets
  always @(posedge clk_sys_in) begin
    tx_cnt <= tx_cnt + tx_tick_in;
    rx_cnt <= rx_cnt + rx_tick_in;
  end
  // one falling edge, each level held four cycles
  task fall_trigger;
    begin
      trigger_pin_out <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      trigger_pin_out <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
    end
  endtask
  task pulse_ext(input integer n);
    repeat (n) begin
      ext_count_pin_out <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      ext_count_pin_out <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
    end
  endtask
endmodule

// [tb/test_timer2_reload_capture_baud.sv]
/* self-checking bench for timer 2 with a read scoreboard.
   assumes tmr2_core, its checker and the pin model are compiled. */
`timescale 1ns/1ps
module test_timer2_reload_capture_baud;
  reg        clk_sys_in = 1'b0;
  reg        rst_in = 1'b1;
  reg  [7:0] addr_in = 8'h00;
  reg  [7:0] wdata_in = 8'h00;
  reg        wr_in = 1'b0;
  reg        rd_in = 1'b0;
  reg        pend_r = 1'b0;
  wire [7:0] rdata_out;
  wire       tx_w, rx_w, trg_w, ext_w, irq_out;
  integer    errors = 0, compares = 0, i, b0, b1;
  integer    seed = 32'h16b91fb6;
  reg [15:0] x, r;
  reg [7:0]  q_exp[$], q_msk[$];
  always #4 clk_sys_in = ~clk_sys_in;
  tmr2_core dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .clk_en_in(1'b1),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .ext_count_pin_in(ext_w), .trigger_pin_in(trg_w),
    .tx_baud_tick_out(tx_w), .rx_baud_tick_out(rx_w), .irq_out(irq_out));
  tmr2_pin_model pm_u (.clk_sys_in(clk_sys_in), .tx_tick_in(tx_w), .rx_tick_in(rx_w),
    .trigger_pin_out(trg_w), .ext_count_pin_out(ext_w));
  task check(input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_sys_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e, input [7:0] m);
    begin
      @(posedge clk_sys_in);
      addr_in <= a;
      rd_in <= 1'b1;
      q_exp.push_back(e & m);
      q_msk.push_back(m);
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
    end
  endtask
  task tally_and_finish;
    begin
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // scoreboard: read data stand in the cycle after the strobe
  always @(posedge clk_sys_in) pend_r <= rd_in;
  always @(negedge clk_sys_in) begin
    if (pend_r) begin
      check(rdata_out & q_msk.pop_front(), q_exp.pop_front());
    end
  end
  initial begin
    #(8 * 40000);
    errors = errors + 1;
    tally_and_finish;
  end
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    for (i = 8'hC8; i < 8'hD0; i = i + 1) rd(i[7:0], 8'h00, 8'hFF);
    rd(8'hD1, 8'h00, 8'hFF);
    x = $random(seed);
    r = $random(seed);
    r[15] = 1'b0;
    wr(8'hC9, x[7:0]);
    wr(8'hCA, x[15:8]);
    rd(8'hC9, x[7:0], 8'hFF);
    rd(8'hCA, x[15:8], 8'hFF);
    $display("test reset and stopped count done");
    // reload mode: carry reloads the counter from the pair and raises the overflow interrupt
    wr(8'hCB, r[7:0]);
    wr(8'hCC, r[15:8]);
    wr(8'hC9, 8'hFE);
    wr(8'hCA, 8'hFF);
    wr(8'hCF, 8'h01);
    wr(8'hC8, 8'h04);
    repeat (6) @(posedge clk_sys_in);
    check(irq_out, 1'b1);
    rd(8'hC8, 8'h84, 8'hFF);
    rd(8'hCE, 8'h01, 8'h01);
    rd(8'hCC, r[15:8], 8'hFF);
    wr(8'hC8, 8'h00);
    wr(8'hD0, 8'h07);
    @(negedge clk_sys_in);
    check(irq_out, 1'b0);
    $display("test reload done");
    // capture with a still external clock, trigger gated off then on
    x = $random(seed);
    wr(8'hC9, x[7:0]);
    wr(8'hCA, x[15:8]);
    wr(8'hC8, 8'h07);
    pm_u.fall_trigger;
    rd(8'hCB, r[7:0], 8'hFF);
    rd(8'hC8, 8'h07, 8'hFF);
    wr(8'hC8, 8'h0F);
    pm_u.fall_trigger;
    rd(8'hCB, x[7:0], 8'hFF);
    rd(8'hCC, x[15:8], 8'hFF);
    rd(8'hC8, 8'h4F, 8'hFF);
    // reload mode with a still count pin: an enabled trigger fall loads the counter from the pair
    wr(8'hC9, ~x[7:0]);
    wr(8'hC8, 8'h0E);
    pm_u.fall_trigger;
    rd(8'hC9, x[7:0], 8'hFF);
    $display("test capture done");
    // baud mode: reload from FFF0 gives a tick every 16 cycles
    wr(8'hC8, 8'h00);
    wr(8'hCB, 8'hF0);
    wr(8'hCC, 8'hFF);
    wr(8'hC9, 8'hF0);
    wr(8'hCA, 8'hFF);
    wr(8'hCD, 8'h02);
    for (i = 0; i < 3; i = i + 1) begin
      if (i == 2) wr(8'hCD, 8'h00);
      wr(8'hC8, i ? 8'h24 : 8'h14);
      b0 = pm_u.tx_cnt;
      b1 = pm_u.rx_cnt;
      repeat (200) @(posedge clk_sys_in);
      check(pm_u.tx_cnt - b0 >= 11, i == 0);
      check(pm_u.rx_cnt - b1 >= 11, i == 1);
    end
    rd(8'hC8, 8'h24, 8'hFF);
    $display("test baud done");
    // power-down freezes the count, then the external pin clocks it
    wr(8'hC8, 8'h00);
    wr(8'hC9, x[7:0]);
    wr(8'hCD, 8'h01);
    wr(8'hC8, 8'h04);
    repeat (20) @(posedge clk_sys_in);
    rd(8'hC9, x[7:0], 8'hFF);
    wr(8'hCD, 8'h00);
    wr(8'hC8, 8'h00);
    wr(8'hC9, 8'h00);
    wr(8'hCA, 8'h00);
    wr(8'hC8, 8'h06);
    pm_u.pulse_ext(5);
    rd(8'hC9, 8'h05, 8'hFF);
    $display("test power-down and pin count done");
    tally_and_finish;
  end
endmodule
